// *** rtl/tve_fifo.sv ***
// Dual-clock FIFO with gray-coded pointers between link and system domains
`timescale 1ns/1ps
module tve_fifo #(
  parameter int W = 27,
  parameter int DEPTH = 32
) (
  input wire logic wr_clk,
  input wire logic wr_rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_clk,
  input wire logic rd_rst_n,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] far_s1;
    logic [AW:0] far_s2;
  } tve_ptr_type;

  tve_ptr_type w_r, w_nxt, r_r, r_nxt;
  logic [W-1:0] mem [DEPTH];
  logic wr_fire, rd_fire;

  ////////////////////////////////////////////////////////////////////////////
  // Full compares against the far pointer with its top two bits inverted
  assign wr_ready = (w_r.gray != {~w_r.far_s2[AW:AW-1], w_r.far_s2[AW-2:0]});
  assign rd_valid = (r_r.gray != r_r.far_s2);
  assign rd_data = mem[r_r.bin[AW-1:0]];
  assign wr_fire = wr_valid & wr_ready;
  assign rd_fire = rd_valid & rd_ready;

  // Write side next state; far_s1 feeds only far_s2
  always_comb begin
    w_nxt = w_r;
    w_nxt.far_s1 = r_r.gray;
    w_nxt.far_s2 = w_r.far_s1;
    if (wr_fire) begin
      w_nxt.bin = w_r.bin + 1'b1;
      w_nxt.gray = w_nxt.bin ^ (w_nxt.bin >> 1);
    end
  end

  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      w_r <= '0;
    end else begin
      w_r <= w_nxt;
    end
  end

  // Storage has no reset: contents are only read behind a valid pointer
  always_ff @(posedge wr_clk) begin
    if (wr_fire) begin
      mem[w_r.bin[AW-1:0]] <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side next state
  always_comb begin
    r_nxt = r_r;
    r_nxt.far_s1 = w_r.gray;
    r_nxt.far_s2 = r_r.far_s1;
    if (rd_fire) begin
      r_nxt.bin = r_r.bin + 1'b1;
      r_nxt.gray = r_nxt.bin ^ (r_nxt.bin >> 1);
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end
endmodule

// *** rtl/tve_input.sv ***
// Video input front end and operating-mode control of the TV encoder
`timescale 1ns/1ps
module tve_input
  import tve_pkg::*;
#(
  parameter int FIFO_DEPTH = TVE_FIFO_DEPTH,
  parameter int LINE_CYC = TVE_LINE_CYC,
  parameter int FIELD_LINES = TVE_FIELD_LINES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic link_pixel_clock,
  input wire logic [TVE_PIX_W-1:0] pixel_data_in,
  input wire logic hsync_in,
  output logic hsync_out,
  output logic hsync_oe,
  input wire logic vsync_in,
  output logic vsync_out,
  output logic vsync_oe,
  input wire logic active_data_qualifier,
  input wire logic path_enable,
  input wire logic mode_interlaced,
  input wire logic clock_master,
  input wire logic [1:0] out_cfg,
  input wire logic ref_clk_oe_en,
  input wire logic sync_direction_sel,
  input wire logic sync_embedded,
  input wire logic mux_mode,
  input wire logic [7:0] ref_div,
  input wire logic crystal_needed,
  input wire logic enc_ready,
  output logic enc_valid,
  output logic [TVE_PIX_W-1:0] enc_pixel,
  output logic enc_hsync,
  output logic enc_vsync,
  output logic enc_active,
  output logic enc_bypass,
  output logic ref_clk_out,
  output logic ref_clk_oe,
  output logic secondary_video_en,
  output logic secondary_video_chroma,
  output logic subcarrier_from_crystal,
  output logic input_overrun,
  output logic res_error,
  output logic line_count_error,
  output logic path_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Link-domain state
  typedef struct packed {
    logic [TVE_WORD_W-1:0] pin_s1;
    logic [TVE_WORD_W-1:0] pin_s2;
    logic [1:0] run_s;
    logic [1:0] mux_s;
    logic phase;
    logic [TVE_HALF_W-1:0] half;
    logic wvalid;
    logic [TVE_WORD_W-1:0] wdata;
    logic ovf;
  } tve_link_type;

  // System-domain state
  typedef struct packed {
    tve_state_type st;
    logic cfg_ilace;
    logic cfg_master;
    tve_out_type cfg_out;
    logic cfg_refoe;
    logic cfg_sydir;
    logic cfg_emb;
    logic cfg_mux;
    logic [7:0] cfg_div;
    logic cfg_xtal;
    logic ovf_s1;
    logic ovf_s2;
    logic overrun;
    logic enc_valid;
    logic [TVE_PIX_W-1:0] enc_pixel;
    logic enc_h;
    logic enc_v;
    logic enc_de;
    logic [TVE_PIX_W-1:0] prev_pix;
    logic prev_de;
    logic [1:0] emb_cnt;
    logic emb_h;
    logic emb_v;
    logic [9:0] px_cnt;
    logic [9:0] ln_cnt;
    logic last_v;
    logic frame_seen;
    logic res_err;
    logic line_err;
    logic [7:0] div_cnt;
    logic ref_clk;
    logic ref_oe;
    logic sec_en;
    logic sec_chroma;
    logic xtal_sc;
    logic [11:0] h_cnt;
    logic [9:0] v_cnt;
    logic gen_h;
    logic gen_v;
    logic sync_oe;
  } tve_sys_type;

  tve_link_type l_r, l_nxt;
  tve_sys_type s_r, s_nxt;

  logic f_wready, f_rvalid, f_rready;
  logic [TVE_WORD_W-1:0] f_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: two-stage pin capture, pairing of multiplexed halves
  always_comb begin
    l_nxt = l_r;
    l_nxt.pin_s1 = {hsync_in, vsync_in, active_data_qualifier, pixel_data_in};
    l_nxt.pin_s2 = l_r.pin_s1;
    // Only the single RUN flop bit crosses, so no decode glitch reaches the synchroniser
    l_nxt.run_s = {l_r.run_s[0], s_r.st[1]};
    l_nxt.mux_s = {l_r.mux_s[0], s_r.cfg_mux};
    l_nxt.wvalid = 1'b0;
    if (!l_r.run_s[1]) begin
      l_nxt.phase = 1'b0;
      l_nxt.ovf = 1'b0;
    end else if (l_r.mux_s[1] && l_r.pin_s2[TVE_BIT_DE]) begin
      // Two-way multiplexed: first half is upper, second completes pixel
      l_nxt.phase = ~l_r.phase;
      l_nxt.half = l_r.pin_s2[TVE_HALF_W-1:0];
      if (l_r.phase) begin
        l_nxt.wvalid = 1'b1;
        l_nxt.wdata = {l_r.pin_s2[TVE_WORD_W-1:TVE_PIX_W], l_r.half,
                       l_r.pin_s2[TVE_HALF_W-1:0]};
      end
    end else begin
      // Unitary transfer, and blanking words in either mode
      l_nxt.phase = 1'b0;
      l_nxt.wvalid = 1'b1;
      l_nxt.wdata = l_r.pin_s2;
    end
    // Link source cannot stall, so a full FIFO is recorded as an overrun
    if (l_r.wvalid && !f_wready) begin
      l_nxt.ovf = 1'b1;
    end
  end

  always_ff @(posedge link_pixel_clock or negedge nrst) begin
    if (!nrst) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  tve_fifo #(
    .W(TVE_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .wr_clk(link_pixel_clock),
    .wr_rst_n(nrst),
    .wr_valid(l_r.wvalid),
    .wr_ready(f_wready),
    .wr_data(l_r.wdata),
    .rd_clk(sys_clk),
    .rd_rst_n(nrst),
    .rd_valid(f_rvalid),
    .rd_ready(f_rready),
    .rd_data(f_rdata)
  );

  // Encoder back-pressure stalls the FIFO drain
  assign f_rready = (s_r.st != TVE_ST_IDLE) && (enc_ready || !s_r.enc_valid);

  ////////////////////////////////////////////////////////////////////////////
  // System domain: mode control, sync sources, filter and checks
  always_comb begin
    logic [TVE_WORD_W-1:0] w;
    logic h, v, de, v_rise, de_fall, pop;
    w = f_rdata;
    h = 1'b0;
    v = 1'b0;
    de = 1'b0;
    v_rise = 1'b0;
    de_fall = 1'b0;
    pop = f_rready && f_rvalid;
    s_nxt = s_r;
    s_nxt.ovf_s1 = l_r.ovf;
    s_nxt.ovf_s2 = s_r.ovf_s1;
    if (s_r.ovf_s2) begin
      s_nxt.overrun = 1'b1;
    end
    // State machine; configuration follows the ports only while idle
    case (s_r.st)
      TVE_ST_IDLE: begin
        s_nxt.cfg_ilace = mode_interlaced;
        s_nxt.cfg_master = clock_master;
        s_nxt.cfg_out = tve_out_type'(out_cfg);
        s_nxt.cfg_refoe = ref_clk_oe_en;
        s_nxt.cfg_sydir = sync_direction_sel;
        s_nxt.cfg_emb = sync_embedded;
        s_nxt.cfg_mux = mux_mode;
        s_nxt.cfg_div = (ref_div == '0) ? TVE_DIV_RST : ref_div;
        s_nxt.cfg_xtal = crystal_needed;
        if (path_enable) begin
          s_nxt.st = TVE_ST_RUN;
          s_nxt.overrun = 1'b0;
          s_nxt.res_err = 1'b0;
          s_nxt.line_err = 1'b0;
          s_nxt.frame_seen = 1'b0;
          s_nxt.px_cnt = '0;
          s_nxt.ln_cnt = '0;
        end
      end
      TVE_ST_RUN: begin
        if (!path_enable) begin
          s_nxt.st = TVE_ST_DRAIN;
        end
      end
      TVE_ST_DRAIN: begin
        if (!f_rvalid && !s_r.enc_valid) begin
          s_nxt.st = TVE_ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = TVE_ST_IDLE;
      end
    endcase

    // Analog output routing from the held configuration
    s_nxt.sec_en = (s_r.cfg_out != TVE_OUT_SINGLE);
    s_nxt.sec_chroma = (s_r.cfg_out == TVE_OUT_SVIDEO);
    s_nxt.xtal_sc = !s_r.cfg_master && s_r.cfg_xtal;

    // Reference clock divider: runs and drives only in master mode
    s_nxt.ref_oe = s_r.cfg_master && s_r.cfg_refoe;
    if (!s_r.cfg_master) begin
      s_nxt.div_cnt = '0;
      s_nxt.ref_clk = 1'b0;
    end else if (s_r.div_cnt >= s_r.cfg_div - 8'h01) begin
      s_nxt.div_cnt = '0;
      s_nxt.ref_clk = ~s_r.ref_clk;
    end else begin
      s_nxt.div_cnt = s_r.div_cnt + 8'h01;
    end

    // Local sync generator, driven out when the direction select is high
    s_nxt.sync_oe = s_r.cfg_sydir;
    if (s_r.h_cnt == 12'(LINE_CYC - 1)) begin
      s_nxt.h_cnt = '0;
      s_nxt.v_cnt = (s_r.v_cnt == 10'(FIELD_LINES - 1)) ? '0 : s_r.v_cnt + 10'd1;
    end else begin
      s_nxt.h_cnt = s_r.h_cnt + 12'd1;
    end
    s_nxt.gen_h = s_r.cfg_sydir && (s_r.h_cnt < 12'(TVE_HSYNC_CYC));
    s_nxt.gen_v = s_r.cfg_sydir && (s_r.v_cnt < 10'(TVE_VSYNC_LINES));

    // Embedded timing code: preamble of FF 00 00 then the flag byte
    if (pop) begin
      if (w[7:0] == TVE_EMB_FF) begin
        s_nxt.emb_cnt = 2'd1;
      end else if (s_r.emb_cnt == 2'd3) begin
        s_nxt.emb_cnt = 2'd0;
        s_nxt.emb_h = w[TVE_EMB_BIT_H];
        s_nxt.emb_v = w[TVE_EMB_BIT_V];
      end else if (s_r.emb_cnt != 2'd0 && w[7:0] == TVE_EMB_00) begin
        s_nxt.emb_cnt = s_r.emb_cnt + 2'd1;
      end else begin
        s_nxt.emb_cnt = 2'd0;
      end
    end

    // Pick the timing source
    if (s_r.cfg_sydir) begin
      h = s_r.gen_h;
      v = s_r.gen_v;
    end else if (s_r.cfg_emb) begin
      h = s_r.emb_h;
      v = s_r.emb_v;
    end else begin
      h = w[TVE_BIT_H];
      v = w[TVE_BIT_V];
    end
    de = w[TVE_BIT_DE];
    v_rise = v && !s_r.last_v;
    de_fall = !de && s_r.prev_de;

    // Encoder hand-off, with the progressive smoothing filter
    if (s_r.enc_valid && enc_ready) begin
      s_nxt.enc_valid = 1'b0;
    end
    if (pop) begin
      s_nxt.enc_valid = 1'b1;
      s_nxt.enc_h = h;
      s_nxt.enc_v = v;
      s_nxt.enc_de = de;
      s_nxt.enc_pixel = w[TVE_PIX_W-1:0];
      if (!s_r.cfg_ilace && de && s_r.prev_de) begin
        for (int c = 0; c < 3; c++) begin
          s_nxt.enc_pixel[c*8 +: 8] = 8'(({1'b0, w[c*8 +: 8]}
                                         + {1'b0, s_r.prev_pix[c*8 +: 8]}) >> 1);
        end
      end
      s_nxt.prev_pix = w[TVE_PIX_W-1:0];
      s_nxt.prev_de = de;
      s_nxt.last_v = v;
      // Active size measurement per line and per field or frame
      if (de) begin
        s_nxt.px_cnt = s_r.px_cnt + 10'd1;
      end
      if (de_fall) begin
        s_nxt.px_cnt = '0;
        s_nxt.ln_cnt = s_r.ln_cnt + 10'd1;
        if (!s_r.cfg_ilace && (s_r.px_cnt < TVE_MIN_W || s_r.px_cnt > TVE_MAX_W)) begin
          s_nxt.res_err = 1'b1;
        end
      end
      if (v_rise) begin
        s_nxt.ln_cnt = '0;
        s_nxt.frame_seen = 1'b1;
        if (s_r.frame_seen && s_r.cfg_ilace && s_r.ln_cnt != TVE_ILACE_480_F
            && s_r.ln_cnt != TVE_ILACE_576_F) begin
          s_nxt.line_err = 1'b1;
        end
        if (s_r.frame_seen && !s_r.cfg_ilace
            && (s_r.ln_cnt < TVE_MIN_H || s_r.ln_cnt > TVE_MAX_H)) begin
          s_nxt.res_err = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.st <= TVE_ST_IDLE;
      s_r.cfg_out <= TVE_OUT_SINGLE;
      s_r.cfg_div <= TVE_DIV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all taken from flops except path_busy, an OR of two state bits
  assign hsync_out = s_r.gen_h;
  assign vsync_out = s_r.gen_v;
  assign hsync_oe = s_r.sync_oe;
  assign vsync_oe = s_r.sync_oe;
  assign enc_valid = s_r.enc_valid;
  assign enc_pixel = s_r.enc_pixel;
  assign enc_hsync = s_r.enc_h;
  assign enc_vsync = s_r.enc_v;
  assign enc_active = s_r.enc_de;
  assign enc_bypass = s_r.cfg_ilace;
  assign ref_clk_out = s_r.ref_clk;
  assign ref_clk_oe = s_r.ref_oe;
  assign secondary_video_en = s_r.sec_en;
  assign secondary_video_chroma = s_r.sec_chroma;
  assign subcarrier_from_crystal = s_r.xtal_sc;
  assign input_overrun = s_r.overrun;
  assign res_error = s_r.res_err;
  assign line_count_error = s_r.line_err;
  assign path_busy = s_r.st[1] | s_r.st[2];

endmodule

// *** rtl/tve_pkg.sv ***
// Shared constants and types for the TV encoder video input front end
package tve_pkg;

  // Link word layout: {hsync, vsync, active, pixel[23:0]}
  localparam int TVE_PIX_W = 24;
  localparam int TVE_WORD_W = 27;
  localparam int TVE_BIT_H = 26;
  localparam int TVE_BIT_V = 25;
  localparam int TVE_BIT_DE = 24;
  localparam int TVE_HALF_W = 12;
  localparam int TVE_FIFO_DEPTH = 32;

  // Timing of the locally generated sync
  localparam int TVE_SYS_CLK_NS = 20;
  localparam int TVE_LINE_NS = 63500;
  localparam int TVE_LINE_CYC = TVE_LINE_NS / TVE_SYS_CLK_NS;
  localparam int TVE_HSYNC_CYC = 64;
  localparam int TVE_VSYNC_LINES = 3;
  localparam int TVE_FIELD_LINES = 262;

  // Resolution limits for progressive input
  localparam logic [9:0] TVE_MIN_W = 10'd220;
  localparam logic [9:0] TVE_MAX_W = 10'd720;
  localparam logic [9:0] TVE_MIN_H = 10'd176;
  localparam logic [9:0] TVE_MAX_H = 10'd576;
  // Active lines per field for 480i and 576i
  localparam logic [9:0] TVE_ILACE_480_F = 10'd240;
  localparam logic [9:0] TVE_ILACE_576_F = 10'd288;

  // Embedded timing code preamble bytes
  localparam logic [7:0] TVE_EMB_FF = 8'hFF;
  localparam logic [7:0] TVE_EMB_00 = 8'h00;
  localparam int TVE_EMB_BIT_V = 5;
  localparam int TVE_EMB_BIT_H = 4;

  // Reset values
  localparam logic [7:0] TVE_DIV_RST = 8'h01;

  // Analog output configuration
  typedef enum logic [1:0] {
    TVE_OUT_SINGLE = 2'b00,
    TVE_OUT_DUAL = 2'b01,
    TVE_OUT_SVIDEO = 2'b10
  } tve_out_type;

  // Input path states
  typedef enum logic [2:0] {
    TVE_ST_IDLE = 3'b001,
    TVE_ST_RUN = 3'b010,
    TVE_ST_DRAIN = 3'b100
  } tve_state_type;

endpackage

// *** tb/tve_input_bench.sv ***
// Self-checking bench for the video input front end
`timescale 1ns/1ps
module tve_input_bench
  import tve_pkg::*;
;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic path_enable = 1'b0;
  logic mode_interlaced = 1'b0;
  logic clock_master = 1'b0;
  logic [1:0] out_cfg = 2'b00;
  logic ref_clk_oe_en = 1'b0;
  logic sync_direction_sel = 1'b0;
  logic mux_mode = 1'b0;
  logic [7:0] ref_div = 8'h01;
  logic crystal_needed = 1'b0;
  logic enc_ready = 1'b0;
  logic src_go = 1'b1;
  logic stall = 1'b0;
  logic chk_on = 1'b0;
  logic [31:0] seed = 32'h88cc_a331;
  logic [7:0] d;
  int n_fail = 0;
  int num_checks = 0;
  int kx = 0;
  int n;
  logic lclk, hs, vs, de, hsync_out, hsync_oe, vsync_out, vsync_oe, enc_valid;
  logic enc_hsync, enc_vsync, enc_active, enc_bypass, ref_clk_out, ref_clk_oe;
  logic secondary_video_en, secondary_video_chroma, subcarrier_from_crystal;
  logic input_overrun, res_error, line_count_error, path_busy;
  logic [TVE_PIX_W-1:0] pix, enc_pixel;
  ////////////////////////////////////////
  // Short line and field so generated sync is quick to observe
  tve_input #(.LINE_CYC(100), .FIELD_LINES(10)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .link_pixel_clock(lclk), .pixel_data_in(pix),
    .hsync_in(hs), .hsync_out(hsync_out), .hsync_oe(hsync_oe), .vsync_in(vs),
    .vsync_out(vsync_out), .vsync_oe(vsync_oe), .active_data_qualifier(de),
    .path_enable(path_enable), .mode_interlaced(mode_interlaced),
    .clock_master(clock_master), .out_cfg(out_cfg), .ref_clk_oe_en(ref_clk_oe_en),
    .sync_direction_sel(sync_direction_sel), .sync_embedded(1'b0), .mux_mode(mux_mode),
    .ref_div(ref_div), .crystal_needed(crystal_needed), .enc_ready(enc_ready),
    .enc_valid(enc_valid), .enc_pixel(enc_pixel), .enc_hsync(enc_hsync),
    .enc_vsync(enc_vsync), .enc_active(enc_active), .enc_bypass(enc_bypass),
    .ref_clk_out(ref_clk_out), .ref_clk_oe(ref_clk_oe),
    .secondary_video_en(secondary_video_en), .secondary_video_chroma(secondary_video_chroma),
    .subcarrier_from_crystal(subcarrier_from_crystal), .input_overrun(input_overrun),
    .res_error(res_error), .line_count_error(line_count_error), .path_busy(path_busy));
  tve_source_model i_src (.go(src_go), .mux(mux_mode), .lclk(lclk), .pix(pix), .hs(hs),
    .vs(vs), .de(de));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] pv(input int i);
    return {8'h00, i[7:0], ~i[7:0], i[7:0] ^ 8'h5a};
  endfunction
  function automatic logic sig(input bit h);
    return h ? hsync_out : ref_clk_out;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Length of one high phase, bounded so a dead output reads as zero
  task automatic meas(input bit h, output int len);
    len = 0;
    for (int t = 0; t < 400 && sig(h) !== 1'b0; t++) @(posedge sys_clk);
    for (int t = 0; t < 400 && sig(h) !== 1'b1; t++) @(posedge sys_clk);
    while (sig(h) === 1'b1 && len < 400) begin
      @(posedge sys_clk);
      len++;
    end
  endtask
  task automatic wait_lvl(input logic v);
    for (int t = 0; t < 3000 && path_busy !== v; t++) @(posedge sys_clk);
    check("path_busy", path_busy, v);
  endtask
  // One run of f fields; a stalled encoder fills the buffer until it refuses
  task automatic run(input logic il, input logic mx, input logic st, input int f);
    mode_interlaced <= il;
    mux_mode <= mx;
    out_cfg <= TVE_OUT_SINGLE;
    sync_direction_sel <= 1'b0;
    repeat (4) @(posedge sys_clk);
    path_enable <= 1'b1;
    stall <= st;
    wait_lvl(1'b1);
    check("overrun", input_overrun, 1'b0);
    kx = 0;
    chk_on <= il & !st;
    out_cfg <= TVE_OUT_SVIDEO;
    src_go <= 1'b1;
    repeat (f * 768 + 20) @(posedge sys_clk);
    src_go <= 1'b0;
    stall <= 1'b0;
    check("chroma_held", secondary_video_chroma, 1'b0);
    path_enable <= 1'b0;
    wait_lvl(1'b0);
    chk_on <= 1'b0;
    if (il && !st) check("pixels", kx, f * 32);
    if (st) check("overrun", input_overrun, 1'b1);
  endtask
  ////////////////////////////////////////
  always #10 sys_clk = ~sys_clk;
  // LFSR seed step; also throttles the encoder side at random
  always @(posedge sys_clk) begin
    seed <= lfsr(seed);
    enc_ready <= !stall && seed[3];
  end
  // Active words leave in order, rebuilt whole from either transfer form
  always @(posedge sys_clk) begin
    if (chk_on && enc_valid === 1'b1 && enc_ready && enc_active === 1'b1) begin
      check("enc_pixel", enc_pixel, pv(kx));
      kx++;
    end
  end
  // Watchdog well beyond the expected run length
  initial begin
    #1_000_000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    src_go <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      out_cfg <= 2'(i % 3);
      {clock_master, ref_clk_oe_en, crystal_needed, sync_direction_sel} <= seed[3:0];
      mode_interlaced <= seed[4];
      repeat (5) @(posedge sys_clk);
      check("sec_en", secondary_video_en, out_cfg != TVE_OUT_SINGLE);
      check("sec_chroma", secondary_video_chroma, out_cfg == TVE_OUT_SVIDEO);
      check("ref_oe", ref_clk_oe, clock_master & ref_clk_oe_en);
      check("ref_slave", ref_clk_out & !clock_master, 1'b0);
      check("xtal_sc", subcarrier_from_crystal, !clock_master & crystal_needed);
      check("sync_oe", {hsync_oe, vsync_oe}, {2{sync_direction_sel}});
      check("bypass", enc_bypass, mode_interlaced);
    end
    clock_master <= 1'b1;
    ref_clk_oe_en <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 8'h00 : {5'h00, seed[2:0]} + 8'h01;
      ref_div <= d;
      repeat (6) @(posedge sys_clk);
      meas(1'b0, n);
      check("ref_half", n, (d == 8'h00) ? 1 : d);
    end
    sync_direction_sel <= 1'b1;
    repeat (4) @(posedge sys_clk);
    meas(1'b1, n);
    check("hsync_len", n, TVE_HSYNC_CYC);
    clock_master <= 1'b0;
    run(1'b1, 1'b0, 1'b0, 3);
    check("line_err", line_count_error, 1'b1);
    run(1'b1, 1'b1, 1'b0, 3);
    run(1'b0, 1'b0, 1'b0, 3);
    check("res_err", res_error, 1'b1);
    run(1'b1, 1'b0, 1'b1, 1);
    run(1'b1, 1'b0, 1'b0, 1);
    tally_and_finish;
  end
endmodule

// *** tb/tve_input_sva.sv ***
// Port checker for the video input front end, with its bind
`timescale 1ns/1ps
module tve_input_sva
  import tve_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [1:0] out_cfg,
  input wire logic clock_master,
  input wire logic ref_clk_oe_en,
  input wire logic crystal_needed,
  input wire logic sync_direction_sel,
  input wire logic mode_interlaced,
  input wire logic path_busy,
  input wire logic enc_ready,
  input wire logic enc_valid,
  input wire logic [TVE_PIX_W-1:0] enc_pixel,
  input wire logic enc_bypass,
  input wire logic ref_clk_out,
  input wire logic ref_clk_oe,
  input wire logic secondary_video_en,
  input wire logic secondary_video_chroma,
  input wire logic subcarrier_from_crystal,
  input wire logic hsync_oe,
  input wire logic vsync_oe
);
  logic [6:0] cfg_w;
  logic [6:0] cfg_q;
  logic calm;
  ////////////////////////////////////////
  // Idle with settings unchanged; outputs lag the ports by two edges, enc_bypass by one
  assign cfg_w = {out_cfg, clock_master, ref_clk_oe_en, crystal_needed, sync_direction_sel,
    mode_interlaced};
  assign calm = !path_busy && cfg_w == cfg_q;
  always_ff @(posedge sys_clk) begin
    cfg_q <= cfg_w;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  sec_off_a: assert property (
    calm [*4] |-> secondary_video_en == (out_cfg != TVE_OUT_SINGLE))
    else $error("secondary output enable wrong");
  sec_chroma_a: assert property (
    calm [*4] |-> secondary_video_chroma == (out_cfg == TVE_OUT_SVIDEO))
    else $error("secondary output content wrong");
  ref_oe_a: assert property (
    calm [*4] |-> ref_clk_oe == (clock_master && ref_clk_oe_en))
    else $error("reference clock enable wrong");
  slave_clk_a: assert property (
    (calm && !clock_master) [*4] |-> !ref_clk_out && !ref_clk_oe)
    else $error("reference clock driven in slave mode");
  xtal_sc_a: assert property (
    calm [*4] |-> subcarrier_from_crystal == (!clock_master && crystal_needed))
    else $error("subcarrier source wrong");
  sync_dir_a: assert property (
    calm [*4] |-> hsync_oe == sync_direction_sel && vsync_oe == sync_direction_sel)
    else $error("sync pin direction wrong");
  bypass_a: assert property (
    calm [*4] |-> enc_bypass == mode_interlaced)
    else $error("filter bypass wrong");
  enc_hold_a: assert property (
    enc_valid && !enc_ready |=> enc_valid && $stable(enc_pixel))
    else $error("encoder word dropped while stalled");
  busy_hold_a: assert property (
    path_busy [*3] |-> $stable(secondary_video_en) && $stable(enc_bypass))
    else $error("settings changed while busy");
endmodule
bind tve_input tve_input_sva i_sva (.*);

// *** tb/tve_source_model.sv ***
// Behavioural video source driving the link pins of the front end
`timescale 1ns/1ps
module tve_source_model
  import tve_pkg::*;
(
  input wire logic go,
  input wire logic mux,
  output logic lclk,
  output logic [TVE_PIX_W-1:0] pix,
  output logic hs,
  output logic vs,
  output logic de
);
  int c = 0;
  int k = 0;
  int p;
  logic act;
  logic [TVE_PIX_W-1:0] pv;
  ////////////////////////////////////////
  // Link clock rests low while go is low between runs, so stale words never clock in
  initial begin
    {lclk, hs, vs, de} = 4'h0;
    pix = '0;
    #7;
    forever #40 lclk = go ? ~lclk : 1'b0;
  end
  // Field of 6 lines of 32 words: vsync on lines 0-1, active from word 8 on lines 2-5
  always @(posedge lclk or negedge go) begin
    p = c % 32;
    act = go && (c / 32) % 6 >= 2 && p >= 8 && p < (mux ? 24 : 16);
    pv = {k[7:0], ~k[7:0], k[7:0] ^ 8'h5a};
    if (!go) begin
      c <= 0;
      k <= 0;
      de <= 1'b0;
      pix <= ~pix;
    end else begin
      c <= c + 1;
      hs <= p < 4;
      vs <= (c / 32) % 6 < 2;
      de <= act;
      if (!act) begin
        pix <= ~pix;
      end else if (!mux) begin
        pix <= pv;
      end else begin
        pix <= p[0] ? {12'h000, pv[11:0]} : {12'h000, pv[23:12]};
      end
      if (act && (!mux || p[0])) begin
        k <= k + 1;
      end
    end
  end
endmodule
